// ===== rtl/tics_fifo.sv
// Purpose: synchronous fifo with valid and ready on both sides
// Assumes: one clock
// Notes: show-ahead output, honest full and empty
`timescale 1ns/1ps
`default_nettype none
module tics_fifo #(parameter int W = 10, parameter int D = 32) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= push ? wr_q + 1'b1 : wr_q;
      rd_q <= pop ? rd_q + 1'b1 : rd_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tics_fifo
`default_nettype wire

// ===== rtl/tics_pkg.sv
// Purpose: types of the transmit input clock select
// Assumes: nothing
// Notes: code 3 on a ternary field reads as mid, like a floating pin
package tics_pkg;
  typedef enum logic [1:0] {TERN_LOW = 2'h0, TERN_MID = 2'h1, TERN_HIGH = 2'h2} tics_tern_type;
  typedef enum logic [1:0] {ALN_LOCKED, ALN_ARM, ALN_ADJUST} tics_aln_type;
  function automatic tics_tern_type tics_tern(input logic [1:0] v);
    return (v == 2'h3) ? TERN_MID : tics_tern_type'(v);
  endfunction
endpackage

// ===== rtl/tics_regs.svh
// Purpose: register map, field positions and constants of the transmit input clock select
// Assumes: apb word access at 100 MHz pclk, two channels
// Notes: ternary selects held as 2 bits, low=0 mid=1 high=2, 3 reads as mid
`ifndef TICS_REGS_SVH
`define TICS_REGS_SVH
`define TICS_CTRL_OFS 12'h000
`define TICS_STAT_OFS 12'h004
`define TICS_PHASE_OFS 12'h008
`define TICS_CTRL_RST 10'h000
`define TICS_F_CKSEL 0
`define TICS_F_RATE 2
`define TICS_F_RXSEL 3
`define TICS_F_DEC 4
`define TICS_F_MODE0 6
`define TICS_F_MODE1 8
`define TICS_F_INV 0
`define TICS_F_MIDX 1
`define TICS_F_MULT 5
`define TICS_F_LOCK 10
`define TICS_F_DROP 11
`define TICS_F_EMPTY 13
`define TICS_MULT_FULL 5'd10
`define TICS_MULT_HALF 5'd20
`define TICS_FIFO_DEPTH 32
`define TICS_NCH 2
`endif

// ===== rtl/tics_top.sv
// Purpose: transmit input clock select, rate select, mode decode and rx output timing
// Assumes: all pin clocks are far below pclk and sampled through two flops
// Notes: registers over apb, pready one cycle after setup
`timescale 1ns/1ps
`include "tics_regs.svh"
`default_nettype none
module tics_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit pins
  input wire logic reference_clock_in,
  input wire logic tx_input_clock_a,
  input wire logic tx_input_clock_b,
  input wire logic tx_phase_align_reset_n,
  input wire logic [15:0] tx_parallel_data_in,
  input wire logic [3:0] tx_char_control_in,
  output wire logic [1:0] tx_input_ready,
  // transmit core side
  output wire logic [19:0] tx_char_out,
  output wire logic [1:0] tx_char_valid,
  input wire logic [1:0] tx_char_ready,
  output logic tx_synth_clock_out,
  output logic [3:0] tx_mode_out,
  // receive decoder side
  input wire logic [15:0] rx_dec_data_in,
  input wire logic [5:0] rx_dec_status_in,
  input wire logic [3:0] rx_raw_low_in,
  input wire logic [1:0] rx_comma_in,
  // receive pins
  output wire logic [15:0] rx_parallel_data_out,
  output wire logic [5:0] rx_char_status_out,
  output logic rx_output_clock_a,
  output logic rx_output_clock_c
);
  import tics_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [9:0] ctrl_q;
  logic [23:0] s1_q;
  logic [23:0] s2_q;
  logic [2:0] s3_q;
  logic [7:0] hp_cnt_q;
  logic [7:0] hp_len_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [3:0] mode_q;
  logic synth_q;
  logic rxck_a_q;
  logic rxck_c_q;
  logic [1:0] drop_q;
  tics_aln_type aln_q;
  tics_aln_type aln_d;
  tics_tern_type ck_sel;
  tics_tern_type dec_sel;
  tics_tern_type mode0;
  tics_tern_type mode1;
  logic rate;
  logic rx_sel;
  logic ref_rise;
  logic ref_fall;
  logic ref_ev;
  logic [1:0] chan_rise;
  logic [1:0] cap_ev;
  logic [1:0] fifo_rdy;
  logic [1:0] fifo_empty;
  logic [1:0] drop_set;
  logic [1:0] drop_clr;
  logic mid_tog;
  logic synth_d;
  logic char_tick;
  logic rx_ev;
  logic adjusting;
  logic invalid;
  logic [4:0] pll_mult;
  logic [3:0] mode_idx;
  logic [15:0] phase_w;
  logic [31:0] stat_w;
  logic [31:0] rd_val;
  logic setup;
  logic acc;
  logic wr_ev;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_phase;
  logic mapped;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****************************************
  // pin synchronisers and edges
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 24'h000000;
      s2_q <= 24'h000000;
      s3_q <= 3'h0;
    end else begin
      s1_q <= {tx_char_control_in, tx_parallel_data_in, tx_phase_align_reset_n,
               tx_input_clock_b, tx_input_clock_a, reference_clock_in};
      s2_q <= s1_q;
      s3_q <= s2_q[2:0];
    end
  end

  assign ref_rise = s2_q[0] && !s3_q[0];
  assign ref_fall = !s2_q[0] && s3_q[0];
  assign chan_rise = s2_q[2:1] & ~s3_q[2:1];

  // ****************************************
  // static select decode
  // ****************************************
  assign ck_sel = tics_tern(ctrl_q[`TICS_F_CKSEL +: 2]);
  assign rate = ctrl_q[`TICS_F_RATE];
  assign rx_sel = ctrl_q[`TICS_F_RXSEL];
  assign dec_sel = tics_tern(ctrl_q[`TICS_F_DEC +: 2]);
  assign mode0 = tics_tern(ctrl_q[`TICS_F_MODE0 +: 2]);
  assign mode1 = tics_tern(ctrl_q[`TICS_F_MODE1 +: 2]);
  assign mode_idx = {2'h0, mode1} * 4'h3 + {2'h0, mode0};
  assign invalid = rate && (ck_sel != TERN_LOW);
  assign pll_mult = rate ? `TICS_MULT_HALF : `TICS_MULT_FULL;
  assign ref_ev = ref_rise || (rate && ck_sel == TERN_LOW && ref_fall);

  // ****************************************
  // transmit synth clock
  // ****************************************
  assign mid_tog = rate && hp_len_q != 8'h00 && hp_cnt_q == {1'b0, hp_len_q[7:1]};
  assign synth_d = (ref_rise || ref_fall || mid_tog) ? !synth_q : synth_q;
  assign char_tick = synth_d && !synth_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp_cnt_q <= 8'h00;
      hp_len_q <= 8'h00;
      synth_q <= 1'b0;
      mode_q <= 4'h0;
    end else begin
      hp_cnt_q <= (ref_rise || ref_fall) ? 8'h00 : hp_cnt_q + 8'(hp_cnt_q != 8'hff);
      hp_len_q <= (ref_rise || ref_fall) ? hp_cnt_q : hp_len_q;
      synth_q <= synth_d;
      mode_q <= mode_idx;
    end
  end

  assign tx_synth_clock_out = synth_q;
  assign tx_mode_out = mode_q;

  // ****************************************
  // phase align control
  // ****************************************
  always_comb begin
    aln_d = aln_q;
    case (aln_q)
      ALN_LOCKED: begin
        if (!s2_q[3] && ref_rise) begin
          aln_d = ALN_ARM;
        end
      end
      ALN_ARM: begin
        if (s2_q[3]) begin
          aln_d = ALN_LOCKED;
        end else if (ref_rise) begin
          aln_d = ALN_ADJUST;
        end
      end
      ALN_ADJUST: begin
        if (s2_q[3]) begin
          aln_d = ALN_LOCKED;
        end
      end
      default: begin
        aln_d = ALN_LOCKED;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aln_q <= ALN_LOCKED;
    end else begin
      aln_q <= aln_d;
    end
  end

  assign adjusting = aln_q == ALN_ADJUST && !(ck_sel == TERN_LOW && !rate);

  // ****************************************
  // per channel capture, fifo and rx output
  // ****************************************
  assign rx_ev = rx_sel ? char_tick : ref_ev;

  for (genvar ch = 0; ch < `TICS_NCH; ch++) begin : g_ch
    logic [9:0] fo_data;
    logic fo_valid;
    logic fo_ready;
    logic [9:0] chr_q;
    logic val_q;
    logic rdy_q;
    logic [7:0] phase_q;
    logic [7:0] rxd_q;
    logic [2:0] rxs_q;

    assign cap_ev[ch] = (ck_sel == TERN_LOW) ? ref_ev :
                        (ck_sel == TERN_MID) ? chan_rise[ch] :
                        chan_rise[0];
    assign drop_set[ch] = cap_ev[ch] && !fifo_rdy[ch];
    assign fo_ready = char_tick && (!val_q || tx_char_ready[ch]);
    assign fifo_empty[ch] = !fo_valid;

    tics_fifo #(.W(10), .D(`TICS_FIFO_DEPTH)) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(cap_ev[ch]),
      .in_ready(fifo_rdy[ch]),
      .in_data({s2_q[20+2*ch +: 2], s2_q[4+8*ch +: 8]}),
      .out_valid(fo_valid),
      .out_ready(fo_ready),
      .out_data(fo_data)
    );

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        chr_q <= 10'h000;
        val_q <= 1'b0;
        rdy_q <= 1'b0;
        phase_q <= 8'h00;
        rxd_q <= 8'h00;
        rxs_q <= 3'h0;
      end else begin
        chr_q <= (fo_ready && fo_valid) ? fo_data : chr_q;
        val_q <= (fo_ready && fo_valid) || (val_q && !tx_char_ready[ch]);
        rdy_q <= fifo_rdy[ch];
        phase_q <= (adjusting && chan_rise[ch]) ? hp_cnt_q : phase_q;
        if (rx_ev) begin
          rxd_q <= rx_dec_data_in[8*ch +: 8];
          rxs_q <= (dec_sel == TERN_LOW) ? {rx_comma_in[ch], rx_raw_low_in[2*ch +: 2]} :
                   rx_dec_status_in[3*ch +: 3];
        end
      end
    end

    assign tx_char_out[10*ch +: 10] = chr_q;
    assign tx_char_valid[ch] = val_q;
    assign tx_input_ready[ch] = rdy_q;
    assign phase_w[8*ch +: 8] = phase_q;
    assign rx_parallel_data_out[8*ch +: 8] = rxd_q;
    assign rx_char_status_out[3*ch +: 3] = rxs_q;
  end

  // ****************************************
  // receive output clocks
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxck_a_q <= 1'b0;
      rxck_c_q <= 1'b0;
    end else begin
      rxck_a_q <= rx_sel ? synth_q : s2_q[0];
      rxck_c_q <= rx_sel ? synth_q : s2_q[0];
    end
  end

  assign rx_output_clock_a = rxck_a_q;
  assign rx_output_clock_c = rxck_c_q;

  // ****************************************
  // apb slave
  // ****************************************
  assign setup = psel && !penable;
  assign acc = psel && penable && pready_q;
  assign wr_ev = acc && pwrite;
  assign hit_ctrl = paddr == `TICS_CTRL_OFS;
  assign hit_stat = paddr == `TICS_STAT_OFS;
  assign hit_phase = paddr == `TICS_PHASE_OFS;
  assign mapped = hit_ctrl || hit_stat || hit_phase;
  assign drop_clr = (wr_ev && hit_stat) ? pwdata[`TICS_F_DROP +: 2] : 2'h0;
  assign stat_w = {17'h00000, fifo_empty, drop_q, aln_q == ALN_LOCKED,
                   pll_mult, mode_idx, invalid};
  assign rd_val = hit_ctrl ? {22'h000000, ctrl_q} :
                  hit_stat ? stat_w :
                  hit_phase ? {16'h0000, phase_w} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      ctrl_q <= `TICS_CTRL_RST;
      drop_q <= 2'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup ? !mapped : (acc ? 1'b0 : pslverr_q);
      prdata_q <= setup ? (pwrite ? 32'h00000000 : rd_val) : (acc ? 32'h00000000 : prdata_q);
      ctrl_q <= (wr_ev && hit_ctrl) ? pwdata[9:0] : ctrl_q;
      drop_q <= drop_set | (drop_q & ~drop_clr);
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ****************************************
  // assertions
  // ****************************************
  a_ref_capture: assert property ((ck_sel == TERN_LOW && cap_ev[1]) |-> ref_ev)
    else $error("capture off reference edge");
  a_own_capture: assert property ((ck_sel == TERN_MID && chan_rise[1]) |-> cap_ev[1])
    else $error("channel b missed own clock");
  a_clka_capture: assert property ((ck_sel == TERN_HIGH) |-> cap_ev[1] == chan_rise[0])
    else $error("channel b not on clock a");
  a_mult_twenty: assert property ((setup && !pwrite && hit_stat && rate)
    |=> prdata_q[`TICS_F_MULT +: 5] == 5'd20)
    else $error("half rate multiplier not twenty");
  a_mult_ten: assert property ((setup && !pwrite && hit_stat && !rate)
    |=> prdata_q[`TICS_F_MULT +: 5] == 5'd10)
    else $error("full rate multiplier not ten");
  a_rxclk_follow: assert property ((!rx_sel && $stable(ctrl_q)) |=>
    rx_output_clock_a == $past(s2_q[0]) && rx_output_clock_c == rx_output_clock_a)
    else $error("rx clock not following reference");
  a_synth_rate: assert property ((ref_rise && !rate) |=> tx_synth_clock_out != $past(synth_q))
    else $error("synth clock missed reference edge");
  a_phase_hold: assert property ((aln_q != ALN_ADJUST) |=> $stable(phase_w))
    else $error("phase moved while locked");
  a_mode_nine: assert property ($stable(ctrl_q)[*2] |-> tx_mode_out <= 4'h8 &&
    tx_mode_out == {2'h0, mode1} * 4'h3 + {2'h0, mode0})
    else $error("mode decode wrong");
  a_rx_update: assert property ($changed(rx_parallel_data_out) |-> $past(rx_ev))
    else $error("rx data changed off its clock");
  a_rx_status: assert property ((rx_ev && dec_sel != TERN_LOW)
    |=> rx_char_status_out[2:0] == $past(rx_dec_status_in[2:0]))
    else $error("decoded status not passed");
  a_half_both: assert property ((rate && ck_sel == TERN_LOW && ref_fall) |-> cap_ev == 2'h3)
    else $error("falling reference edge not sampled");

  c_half_rate: cover property (rate && ref_fall && cap_ev[0]);
  c_own_clock: cover property (ck_sel == TERN_MID && cap_ev == 2'h2);
  c_fifo_full: cover property (!fifo_rdy[0] ##1 fifo_rdy[0]);
  c_align_lock: cover property (aln_q == ALN_ADJUST ##1 aln_q == ALN_LOCKED);
endmodule // tics_top
`default_nettype wire

// ===== verification/testbench.sv
// Purpose: self-checking bench of the transmit input clock select
// Assumes: host model drives the pins, bench drives apb and the rx side
// Notes: seed fixed, reference left low between tests
`timescale 1ns/1ps
`include "tics_regs.svh"
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, synth_q;
  logic reference_clock_in, tx_input_clock_a, tx_input_clock_b, tx_phase_align_reset_n;
  logic [15:0] tx_parallel_data_in, rx_parallel_data_out, pd;
  logic [3:0] tx_char_control_in, tx_mode_out;
  logic [1:0] tx_char_ready, tx_input_ready, tx_char_valid;
  logic [19:0] tx_char_out, w;
  logic tx_synth_clock_out, rx_output_clock_a, rx_output_clock_c;
  logic [15:0] rx_dec_data_in = 16'h0;
  logic [5:0] rx_dec_status_in = 6'h0, rx_char_status_out;
  logic [3:0] rx_raw_low_in = 4'h0;
  logic [1:0] rx_comma_in = 2'h0;
  logic [9:0] exp0[$], exp1[$], got0[$], got1[$];
  int mismatches = 0, checked = 0, cycles = 0, rises = 0;

  always #5 pclk = ~pclk;
  tics_top tics_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .reference_clock_in, .tx_input_clock_a, .tx_input_clock_b,
    .tx_phase_align_reset_n, .tx_parallel_data_in, .tx_char_control_in, .tx_input_ready,
    .tx_char_out, .tx_char_valid, .tx_char_ready, .tx_synth_clock_out, .tx_mode_out,
    .rx_dec_data_in, .rx_dec_status_in, .rx_raw_low_in, .rx_comma_in, .rx_parallel_data_out,
    .rx_char_status_out, .rx_output_clock_a, .rx_output_clock_c);
  tics_host_model tics_host_model_i (.pclk, .reference_clock_in, .tx_input_clock_a,
    .tx_input_clock_b, .tx_phase_align_reset_n, .tx_parallel_data_in, .tx_char_control_in,
    .tx_char_ready);

  // consumer log, synth rise count and hang limit
  always @(posedge pclk) begin
    cycles++;
    synth_q <= tx_synth_clock_out;
    if (tx_synth_clock_out === 1'b1 && synth_q === 1'b0) rises++;
    if (tx_char_valid[0] === 1'b1 && tx_char_ready[0] === 1'b1) got0.push_back(tx_char_out[9:0]);
    if (tx_char_valid[1] === 1'b1 && tx_char_ready[1] === 1'b1) got1.push_back(tx_char_out[19:10]);
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    exp0.delete();
    exp1.delete();
    got0.delete();
    got1.delete();
    tics_host_model_i.set_ready(2'b00);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // one full reference period, rx clocks must track the reference level
  task automatic period(input logic [19:0] v);
    tics_host_model_i.put(0, v);
    `CHK("rx clock a", reference_clock_in, rx_output_clock_a)
    `CHK("rx clock c", reference_clock_in, rx_output_clock_c)
    tics_host_model_i.put(0, v);
  endtask
  task automatic cmpq(input int n);
    for (int i = 0; i < n; i++) begin
      `CHK("ch0 word", exp0[i], got0[i])
      `CHK("ch1 word", exp1[i], got1[i])
    end
  endtask
  task automatic push(input logic [19:0] v);
    exp0.push_back(v[9:0]);
    exp1.push_back(v[19:10]);
  endtask
  function automatic logic [5:0] st_exp(input int d);
    if (d == 0) return {rx_comma_in[1], rx_raw_low_in[3:2], rx_comma_in[0], rx_raw_low_in[1:0]};
    return rx_dec_status_in;
  endfunction

  initial begin
    void'($urandom(94963));
    do_reset();
    apb(0, `TICS_CTRL_OFS, 0);
    `CHK("ctrl reset", 32'h0, rd)
    apb(0, `TICS_STAT_OFS, 0);
    `CHK("mult full", `TICS_MULT_FULL, rd[9:5])
    `CHK("fifo empty", 2'b11, rd[14:13])
    apb(0, 12'h00c, 0);
    `CHK("unmapped err", 1'b1, err)
    apb(1, `TICS_CTRL_OFS, 32'h4);
    apb(0, `TICS_STAT_OFS, 0);
    `CHK("mult half", `TICS_MULT_HALF, rd[9:5])
    `CHK("combo ok", 1'b0, rd[0])
    for (int c = 1; c < 3; c++) begin
      apb(1, `TICS_CTRL_OFS, 32'h4 | c);
      apb(0, `TICS_STAT_OFS, 0);
      `CHK("combo bad", 1'b1, rd[0])
    end
    for (int m = 0; m < 9; m++) begin
      apb(1, `TICS_CTRL_OFS, ((m / 3) << 8) | ((m % 3) << 6));
      apb(0, `TICS_STAT_OFS, 0);
      `CHK("mode out", m[3:0], tx_mode_out)
      `CHK("mode stat", m[3:0], rd[4:1])
    end
    $display("test static done");
    do_reset();
    tics_host_model_i.set_ready(2'b11);
    rises = 0;
    for (int i = 0; i < 16; i++) begin
      w = 20'($urandom);
      if (i < 12) push(w);
      period(w);
    end
    cmpq(12);
    `CHK("synth rises", 16, rises)
    $display("test reference capture done");
    do_reset();
    apb(1, `TICS_CTRL_OFS, 32'h4);
    tics_host_model_i.set_ready(2'b11);
    rises = 0;
    for (int i = 0; i < 8; i++) begin
      w = 20'($urandom);
      push(w);
      push(w);
      period(w);
    end
    cmpq(12);
    `CHK("synth double", 16, rises)
    $display("test half rate done");
    do_reset();
    apb(1, `TICS_CTRL_OFS, 32'h2);
    for (int i = 0; i < 33; i++) begin
      w = 20'($urandom);
      if (i < 32) push(w);
      tics_host_model_i.put(1, w);
    end
    `CHK("input ready", 2'b00, tx_input_ready)
    apb(0, `TICS_STAT_OFS, 0);
    `CHK("drop set", 2'b11, rd[12:11])
    `CHK("fifo full", 2'b00, rd[14:13])
    apb(1, `TICS_STAT_OFS, 32'h1800);
    apb(0, `TICS_STAT_OFS, 0);
    `CHK("drop clear", 2'b00, rd[12:11])
    tics_host_model_i.set_ready(2'b11);
    repeat (36) period(20'($urandom));
    cmpq(32);
    `CHK("drained", 32, got0.size())
    apb(0, `TICS_STAT_OFS, 0);
    `CHK("fifo empty", 2'b11, rd[14:13])
    $display("test fill and drain done");
    do_reset();
    apb(1, `TICS_CTRL_OFS, 32'h1);
    repeat (3) tics_host_model_i.put(2, 20'($urandom));
    apb(0, `TICS_STAT_OFS, 0);
    `CHK("own clock", 2'b01, rd[14:13])
    tics_host_model_i.set_align(1'b0);
    repeat (2) period(20'($urandom));
    apb(0, `TICS_STAT_OFS, 0);
    `CHK("align adjust", 1'b0, rd[10])
    tics_host_model_i.put(2, 20'($urandom));
    apb(0, `TICS_PHASE_OFS, 0);
    `CHK("phase ch0", 8'h00, rd[7:0])
    `CHK("phase ch1", 1'b1, rd[15:8] != 8'h00)
    tics_host_model_i.set_align(1'b1);
    period(20'($urandom));
    apb(0, `TICS_STAT_OFS, 0);
    `CHK("align locked", 1'b1, rd[10])
    $display("test own clocks done");
    do_reset();
    pd = 16'h0000;
    for (int d = 0; d < 3; d++) begin
      apb(1, `TICS_CTRL_OFS, (d << 4) | ((d / 2) << 3));
      rx_dec_data_in <= 16'($urandom);
      rx_dec_status_in <= 6'($urandom);
      rx_raw_low_in <= 4'($urandom);
      rx_comma_in <= 2'($urandom);
      repeat (6) @(posedge pclk);
      `CHK("rx held", pd, rx_parallel_data_out)
      period(20'($urandom));
      `CHK("rx data", rx_dec_data_in, rx_parallel_data_out)
      `CHK("rx status", st_exp(d), rx_char_status_out)
      pd = rx_dec_data_in;
    end
    $display("test receive done");
    test_done();
  end
endmodule // testbench
`default_nettype wire

// ===== verification/tics_host_model.sv
// Purpose: host logic model driving the transmit pins and taking transmit chars
// Assumes: every pin change is made just after a pclk rising edge
// Notes: pin clocks stand still between calls, words held around each edge
`timescale 1ns/1ps
`default_nettype none
module tics_host_model (
  // clock
  input wire logic pclk,
  // transmit pins
  output logic reference_clock_in,
  output logic tx_input_clock_a,
  output logic tx_input_clock_b,
  output logic tx_phase_align_reset_n,
  output logic [15:0] tx_parallel_data_in,
  output logic [3:0] tx_char_control_in,
  // consumer side
  output logic [1:0] tx_char_ready
);
  initial begin
    reference_clock_in = 1'b0;
    tx_input_clock_a = 1'b0;
    tx_input_clock_b = 1'b0;
    tx_phase_align_reset_n = 1'b1;
    tx_parallel_data_in = 16'h0000;
    tx_char_control_in = 4'h0;
    tx_char_ready = 2'b00;
  end
  // ****************
  // pin edges
  // ****************
  // src 0 toggles the reference, 1 pulses clock a, 2 pulses clock b
  // clocks derive from pclk so they stay coherent with the synth clock
  task automatic put(input int src, input logic [19:0] w);
    @(posedge pclk);
    tx_parallel_data_in <= {w[17:10], w[7:0]};
    tx_char_control_in <= {w[19:18], w[9:8]};
    repeat (3) @(posedge pclk);
    case (src)
      0: reference_clock_in <= ~reference_clock_in;
      1: tx_input_clock_a <= 1'b1;
      default: tx_input_clock_b <= 1'b1;
    endcase
    repeat (4) @(posedge pclk);
    tx_input_clock_a <= 1'b0;
    tx_input_clock_b <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // drives the phase align reset pin, low arms an align on the next reference rise and starts it on the rise after, high relocks
  task automatic set_align(input logic v);
    @(posedge pclk);
    tx_phase_align_reset_n <= v;
  endtask
  task automatic set_ready(input logic [1:0] v);
    @(posedge pclk);
    tx_char_ready <= v;
  endtask
endmodule // tics_host_model
`default_nettype wire
